/* design/dmib_pkg.sv */
// Purpose: Shared constants and types for the mode, interface, scratch
//          memory and broadcast register group of a dual smart DAC.
// Assumes: One 20 MHz clock; host protocol engines decode the frames.
// Notes:   Offsets are byte-wide register addresses as the host sees them.
//
// Functional notes
// - Protect with action 00 puts outputs straight into Hi-Z, no slew.
// - Protect with action 01 jumps to stored code, then Hi-Z.
// - Protect with action 10 slews to margin-low code, then Hi-Z.
// - Protect with action 11 slews to margin-high code, then Hi-Z.
// - Interface bit 12 enables the I2C bus timeout; resets to zero.
// - Interface bit 8 enables PMBus operation; resets to zero.
// - Interface bit 2 selects fast readback output timing.
// - Interface bit 0 routes serial readback data onto the GPIO pin.
// - Pointer field bits 7-0 selects the next scratch memory location.
// - Each scratch data write advances the pointer by one.
// - Scratch data access moves a full 16-bit word at the pointer.
// - Broadcast bits 15-4 become every enabled channel's code at once, except a channel that is slewing.
// - Broadcast code is straight binary, MSB at bit 15; bits 3-0 ignored.
// - Ten-bit variant uses upper ten field bits, two lowest ignored.
// - Only channels with broadcast enable set take the broadcast code.
// - PMBus page FFh command E9h reaches the device-mode register.
// - PMBus page FFh: pointer at EFh, scratch data at F0h.
// - PMBus page FFh command F1h reaches the broadcast register.
// - Page select answers command 00h on every page, resets to 0300h.
// - Page number sits in bits 15-8, resets to 03h, low byte ignored.
// - GPIO input code 0101: falling pin edge asserts protect.

package dmib_pkg;

	// ----------------------------------------------------------------
	// Register offsets and PMBus command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_DEV_MODE = 8'h25;
	localparam logic [7:0] ADDR_IFC = 8'h26;
	localparam logic [7:0] ADDR_PTR = 8'h2B;
	localparam logic [7:0] ADDR_DATA = 8'h2C;
	localparam logic [7:0] ADDR_BCAST = 8'h50;
	localparam logic [7:0] PM_PAGE_CMD = 8'h00;
	localparam logic [7:0] PM_CFG_PAGE = 8'hFF;
	localparam logic [7:0] PM_DEV_MODE = 8'hE9;
	localparam logic [7:0] PM_PTR = 8'hEF;
	localparam logic [7:0] PM_DATA = 8'hF0;
	localparam logic [7:0] PM_BCAST = 8'hF1;

	// ----------------------------------------------------------------
	// Reset values, writable masks, field positions
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_DEV_MODE = 16'h0000;
	localparam logic [15:0] RST_IFC = 16'h0000;
	localparam logic [7:0] RST_PTR = 8'h00;
	localparam logic [15:0] RST_BCAST = 16'h0000;
	localparam logic [15:0] RST_PAGE_REG = 16'h0300;
	localparam logic [15:0] MASK_IFC = 16'h1105;
	localparam logic [15:0] MASK_BCAST = 16'hFFF0;
	localparam int PROT_LSB = 8;
	localparam int LOWPWR_BIT = 13;
	localparam int TIMEOUT_BIT = 12;
	localparam int PMBUS_BIT = 8;
	localparam int FAST_BIT = 2;
	localparam int SDO_BIT = 0;
	localparam int BC_MSB = 15;
	localparam logic [3:0] GPI_PROTECT = 4'h5;

	// ----------------------------------------------------------------
	// Timing: one slew step per interval
	// ----------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int SLEW_STEP_NS = 1000;
	localparam int SLEW_CYC = (SLEW_STEP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		ACT_HIZ = 2'b00,
		ACT_NVM = 2'b01,
		ACT_MLOW = 2'b10,
		ACT_MHIGH = 2'b11
	} dmib_act_t;

	typedef enum logic [1:0] {
		CH_RUN = 2'b00,
		CH_SLEW = 2'b01,
		CH_OFF = 2'b10
	} dmib_ch_st_t;

endpackage

/* design/dmib_sram.sv */
// Purpose: Scratch word store, flip-flop based, indexed by pointer.
// Assumes: One write port, one combinational read port.
// Notes:   Contents reset to zero.
`timescale 1ns/10ps

module dmib_sram #(
	parameter int DEPTH = 256,
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] addr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
	} dmib_sram_st_t;

	dmib_sram_st_t s_q;
	dmib_sram_st_t s_d;

	if (DEPTH < 2 || W < 1)
		$error("dmib_sram: bad geometry");

	always_comb
	begin
		s_d = s_q;
		if (wr_en)
			s_d.mem[addr] = wdata;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rdata = s_q.mem[addr];

	a_word_store: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en |=> s_q.mem[$past(addr)] == $past(wdata))
		else $error("scratch word not stored");

endmodule

/* design/dmib_chan.sv */
// Purpose: One output channel code holder with protect sequencing.
// Assumes: Protect request is a one-cycle pulse; tick paces slewing.
// Notes:   Hi-Z power-down is sticky until reset.
`timescale 1ns/10ps

module dmib_chan
	import dmib_pkg::*;
#(
	parameter int RES = 12
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic bc_load,
	input wire logic bc_en,
	input wire logic [RES-1:0] bc_code,
	input wire logic protect_go,
	input wire logic [1:0] action,
	input wire logic [RES-1:0] nvm_code,
	input wire logic [RES-1:0] mlow,
	input wire logic [RES-1:0] mhigh,
	output logic [RES-1:0] code,
	output logic hiz
);

	typedef struct packed {
		dmib_ch_st_t st;
		logic [RES-1:0] code;
		logic [RES-1:0] target;
		logic hiz;
	} dmib_chan_st_t;

	dmib_chan_st_t s_q;
	dmib_chan_st_t s_d;

	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			CH_RUN:
			begin
				if (protect_go)
				begin
					case (dmib_act_t'(action))
						ACT_HIZ:
						begin
							s_d.hiz = 1'b1;
							s_d.st = CH_OFF;
						end
						ACT_NVM:
						begin
							s_d.code = nvm_code;
							s_d.hiz = 1'b1;
							s_d.st = CH_OFF;
						end
						ACT_MLOW:
						begin
							s_d.target = mlow;
							s_d.st = CH_SLEW;
						end
						default:
						begin
							s_d.target = mhigh;
							s_d.st = CH_SLEW;
						end
					endcase
				end
				else if (bc_load && bc_en)
					s_d.code = bc_code;
			end
			CH_SLEW:
			begin
				if (s_q.code == s_q.target)
				begin
					s_d.hiz = 1'b1;
					s_d.st = CH_OFF;
				end
				else if (tick && s_q.code < s_q.target)
					s_d.code = s_q.code + 1'b1;
				else if (tick)
					s_d.code = s_q.code - 1'b1;
			end
			CH_OFF:
			begin
				// Code still loadable while off; only reset ends Hi-Z, and reset clears the code
				if (bc_load && bc_en)
					s_d.code = bc_code;
			end
			default:
				s_d.st = CH_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '{st: CH_RUN, code: '0, target: '0, hiz: 1'b0};
		else
			s_q <= s_d;
	end

	assign code = s_q.code;
	assign hiz = s_q.hiz;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_hiz_direct: assert property (
		s_q.st == CH_RUN && protect_go && action == 2'b00
		|=> hiz && $stable(code))
		else $error("action 00 did not go straight to Hi-Z");
	a_nvm_jump: assert property (
		s_q.st == CH_RUN && protect_go && action == 2'b01
		|=> hiz && code == $past(nvm_code))
		else $error("action 01 did not jump to stored code");
	a_slew_down: assert property (
		s_q.st == CH_SLEW && tick && s_q.code > s_q.target
		|=> !hiz && code == $past(s_q.code) - 1'b1)
		else $error("slew toward margin-low stepped wrongly");
	a_slew_up: assert property (
		s_q.st == CH_RUN && protect_go && action == 2'b11
		|=> s_q.st == CH_SLEW && s_q.target == $past(mhigh) && !hiz)
		else $error("action 11 did not start slewing to margin-high");
	a_bcast_take: assert property (
		s_q.st == CH_RUN && !protect_go && bc_load && bc_en
		|=> code == $past(bc_code))
		else $error("broadcast code not applied");
	a_bcast_skip: assert property (
		s_q.st != CH_SLEW && !protect_go && !bc_en |=> $stable(code))
		else $error("channel without broadcast enable changed code");

	c_slew_done: cover property (
		s_q.st == CH_SLEW ##1 s_q.st == CH_OFF);

endmodule

/* design/dmib_regs.sv */
// Purpose: Mode, interface, scratch memory and broadcast register group.
// Assumes: Protocol engines hand over decoded single-word accesses;
//          acc_pmbus marks a PMBus access whose address is a command.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/10ps

module dmib_regs
	import dmib_pkg::*;
#(
	parameter int NCH = 2,
	parameter int RES = 12,
	parameter int SRAM_DEPTH = 256,
	parameter int SLEW_CYCLES = SLEW_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic acc_pmbus,
	input wire logic [7:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	output logic [15:0] rd_data_q,
	output logic rd_valid_q,
	input wire logic gpi_enable,
	input wire logic [3:0] gpi_config,
	input wire logic gpio_in,
	input wire logic spi_sdo,
	input wire logic [NCH-1:0] channel_broadcast_enable,
	input wire logic [NCH*RES-1:0] nvm_code,
	input wire logic [NCH*RES-1:0] margin_low,
	input wire logic [NCH*RES-1:0] margin_high,
	output logic [NCH*RES-1:0] dac_code,
	output logic [NCH-1:0] dac_hiz,
	output logic low_power_select_q,
	output logic i2c_timeout_en_q,
	output logic pmbus_en_q,
	output logic fast_readback_enable_q,
	output logic gpio_out_q,
	output logic gpio_oe_q
);

	localparam int CW = $clog2(SLEW_CYCLES + 1);
	localparam int PW = $clog2(SRAM_DEPTH);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (RES != 12 && RES != 10)
		$error("dmib_regs: RES must be 12 or 10");
	if (NCH < 1)
		$error("dmib_regs: NCH must be at least 1");
	if (SRAM_DEPTH != 256)
		$error("dmib_regs: pointer field is eight bits wide");
	// One cycle would leave the tick stuck high instead of pulsing
	if (SLEW_CYCLES < 2)
		$error("dmib_regs: SLEW_CYCLES must be at least 2");

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] dev_mode;
		logic [15:0] ifc;
		logic [PW-1:0] ptr;
		logic [15:0] bcast;
		logic [7:0] page;
		logic [15:0] rd_data;
		logic rd_valid;
		logic gpio_prev;
		logic protect_go;
		logic [CW-1:0] cnt;
		logic tick;
		logic gpio_out;
		logic gpio_oe;
	} dmib_regs_st_t;

	dmib_regs_st_t s_q;
	dmib_regs_st_t s_d;

	logic [15:0] sram_rdata;
	logic pm_ok;
	logic cfg_page;
	logic sel_dev;
	logic sel_ifc;
	logic sel_ptr;
	logic sel_data;
	logic sel_bcast;
	logic sel_page;
	logic bc_load;
	logic [RES-1:0] bc_code;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// PMBus writes are dropped and PMBus reads return zero while PMBus is disabled
	assign pm_ok = acc_pmbus && s_q.ifc[PMBUS_BIT];
	assign cfg_page = s_q.page == PM_CFG_PAGE;
	assign sel_page = pm_ok && acc_addr == PM_PAGE_CMD;
	assign sel_dev = acc_pmbus
		? (pm_ok && cfg_page && acc_addr == PM_DEV_MODE)
		: acc_addr == ADDR_DEV_MODE;
	assign sel_ifc = !acc_pmbus && acc_addr == ADDR_IFC;
	assign sel_ptr = acc_pmbus
		? (pm_ok && cfg_page && acc_addr == PM_PTR)
		: acc_addr == ADDR_PTR;
	assign sel_data = acc_pmbus
		? (pm_ok && cfg_page && acc_addr == PM_DATA)
		: acc_addr == ADDR_DATA;
	assign sel_bcast = acc_pmbus
		? (pm_ok && cfg_page && acc_addr == PM_BCAST)
		: acc_addr == ADDR_BCAST;

	// Left-aligned straight binary; unused low bits fall away
	assign bc_code = acc_wdata[BC_MSB -: RES];
	assign bc_load = acc_wr && sel_bcast;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		s_d.tick = 1'b0;
		s_d.protect_go = 1'b0;

		if (acc_wr)
		begin
			if (sel_dev)
				s_d.dev_mode = acc_wdata;
			if (sel_ifc)
				s_d.ifc = acc_wdata & MASK_IFC;
			if (sel_ptr)
				s_d.ptr = acc_wdata[PW-1:0];
			if (sel_data)
				s_d.ptr = s_q.ptr + 1'b1;
			if (sel_bcast)
				s_d.bcast = acc_wdata & MASK_BCAST;
			if (sel_page)
				s_d.page = acc_wdata[15:8];
		end
		else if (acc_rd)
		begin
			// Pointer untouched on reads
			s_d.rd_valid = 1'b1;
			if (sel_dev)
				s_d.rd_data = s_q.dev_mode;
			else if (sel_ifc)
				s_d.rd_data = s_q.ifc;
			else if (sel_ptr)
				s_d.rd_data = {{(16 - PW){1'b0}}, s_q.ptr};
			else if (sel_data)
				s_d.rd_data = sram_rdata;
			else if (sel_bcast)
				s_d.rd_data = s_q.bcast;
			else if (sel_page)
				s_d.rd_data = {s_q.page, 8'h00};
			else
				s_d.rd_data = 16'h0000;
		end

		// Slew pacing divider
		if (s_q.cnt >= CW'(SLEW_CYCLES - 1))
		begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end
		else
			s_d.cnt = s_q.cnt + 1'b1;

		// Protect on falling pin edge only; a low held through reset fires once, then nothing
		s_d.gpio_prev = gpio_in;
		if (gpi_enable && gpi_config == GPI_PROTECT
			&& s_q.gpio_prev && !gpio_in)
			s_d.protect_go = 1'b1;

		// Readback pin: driven only when routed
		s_d.gpio_oe = s_q.ifc[SDO_BIT];
		s_d.gpio_out = s_q.ifc[SDO_BIT] && spi_sdo;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.dev_mode <= RST_DEV_MODE;
			s_q.ifc <= RST_IFC;
			s_q.ptr <= RST_PTR;
			s_q.bcast <= RST_BCAST;
			s_q.page <= RST_PAGE_REG[15:8];
			s_q.gpio_prev <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data_q = s_q.rd_data;
	assign rd_valid_q = s_q.rd_valid;
	assign low_power_select_q = s_q.dev_mode[LOWPWR_BIT];
	assign i2c_timeout_en_q = s_q.ifc[TIMEOUT_BIT];
	assign pmbus_en_q = s_q.ifc[PMBUS_BIT];
	assign fast_readback_enable_q = s_q.ifc[FAST_BIT];
	assign gpio_out_q = s_q.gpio_out;
	assign gpio_oe_q = s_q.gpio_oe;

	// ----------------------------------------------------------------
	// Scratch store and channels
	// ----------------------------------------------------------------
	dmib_sram #(
		.DEPTH(SRAM_DEPTH),
		.W(16)
	) u_sram (
		.clock(clock),
		.rst_n(rst_n),
		.wr_en(acc_wr && sel_data),
		.addr(s_q.ptr),
		.wdata(acc_wdata),
		.rdata(sram_rdata)
	);

	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		dmib_chan #(
			.RES(RES)
		) u_ch (
			.clock(clock),
			.rst_n(rst_n),
			.tick(s_q.tick),
			.bc_load(bc_load),
			.bc_en(channel_broadcast_enable[g]),
			.bc_code(bc_code),
			.protect_go(s_q.protect_go),
			.action(s_q.dev_mode[PROT_LSB +: 2]),
			.nvm_code(nvm_code[g*RES +: RES]),
			.mlow(margin_low[g*RES +: RES]),
			.mhigh(margin_high[g*RES +: RES]),
			.code(dac_code[g*RES +: RES]),
			.hiz(dac_hiz[g])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_ptr_load: assert property (
		acc_wr && !acc_pmbus && acc_addr == 8'h2B
		|=> s_q.ptr == $past(acc_wdata[7:0]))
		else $error("pointer write not taken");
	a_ptr_advance: assert property (
		acc_wr && !acc_pmbus && acc_addr == 8'h2C
		|=> s_q.ptr == $past(s_q.ptr) + 8'h01)
		else $error("pointer did not advance after data write");
	a_ptr_read_hold: assert property (
		!acc_wr && acc_rd |=> $stable(s_q.ptr))
		else $error("pointer moved on read");
	a_word_readback: assert property (
		acc_wr && sel_data
		##2 !acc_wr && acc_rd && sel_ptr
		##2 acc_wr && sel_ptr && acc_wdata[7:0] == $past(s_q.ptr, 4)
		##2 !acc_wr && acc_rd && sel_data
		|=> rd_valid_q && rd_data_q == $past(acc_wdata, 7))
		else $error("scratch word read back wrong");
	a_pmbus_gate: assert property (
		acc_wr && acc_pmbus && !pmbus_en_q |=> $stable(s_q.dev_mode)
			&& $stable(s_q.page) && $stable(s_q.bcast))
		else $error("PMBus write acted while disabled");
	a_pm_devmode: assert property (
		acc_wr && acc_pmbus && pmbus_en_q && s_q.page == 8'hFF
		&& acc_addr == 8'hE9 |=> s_q.dev_mode == $past(acc_wdata))
		else $error("PMBus E9h on page FFh missed device mode");
	a_pm_bcast: assert property (
		acc_wr && acc_pmbus && pmbus_en_q && s_q.page == 8'hFF
		&& acc_addr == 8'hF1
		|=> s_q.bcast == ($past(acc_wdata) & 16'hFFF0))
		else $error("PMBus F1h on page FFh missed broadcast");
	a_page_low: assert property (
		acc_rd && !acc_wr && sel_page |=> rd_data_q[7:0] == 8'h00)
		else $error("page register low byte not zero");
	a_timeout_bit: assert property (
		acc_wr && !acc_pmbus && acc_addr == 8'h26
		|=> i2c_timeout_en_q == $past(acc_wdata[12])
			&& fast_readback_enable_q == $past(acc_wdata[2]))
		else $error("interface bits not reflected");
	a_pin_route: assert property (
		!i2c_timeout_en_q || 1'b1 |=> gpio_oe_q == $past(s_q.ifc[0])
			&& (gpio_out_q == ($past(s_q.ifc[0]) && $past(spi_sdo))))
		else $error("readback pin routing wrong");
	a_protect_edge: assert property (
		gpi_enable && gpi_config == 4'h5 && s_q.gpio_prev && !gpio_in
		|=> s_q.protect_go ##1 !s_q.protect_go)
		else $error("falling edge did not raise protect once");
	a_tick_period: assert property (
		s_q.tick |=> !s_q.tick)
		else $error("slew tick wider than one cycle");

	// ----------------------------------------------------------------
	// Register bus checks
	// ----------------------------------------------------------------
	a_ifc_mask: assert property (
		acc_wr && !acc_pmbus && acc_addr == ADDR_IFC
		|=> s_q.ifc == ($past(acc_wdata) & MASK_IFC))
		else $error("interface write not masked to its fields");
	a_pm_ptr: assert property (
		acc_wr && acc_pmbus && pmbus_en_q && s_q.page == PM_CFG_PAGE
		&& acc_addr == PM_PTR |=> s_q.ptr == $past(acc_wdata[7:0]))
		else $error("PMBus EFh on page FFh missed pointer");
	a_page_write: assert property (
		acc_wr && sel_page |=> s_q.page == $past(acc_wdata[15:8]))
		else $error("page number not taken from high byte");
	a_bcast_store: assert property (
		acc_wr && !acc_pmbus && acc_addr == ADDR_BCAST
		|=> s_q.bcast == ($past(acc_wdata) & MASK_BCAST))
		else $error("broadcast write not masked");
	a_off_page: assert property (
		acc_rd && !acc_wr && acc_pmbus && s_q.page != PM_CFG_PAGE
		&& acc_addr == PM_DEV_MODE |=> rd_data_q == 16'h0000)
		else $error("device mode answered off the config page");
	a_pm_off_rd: assert property (
		acc_rd && !acc_wr && acc_pmbus && !pmbus_en_q
		|=> rd_valid_q && rd_data_q == 16'h0000)
		else $error("PMBus read answered while disabled");
	a_rd_answer: assert property (
		acc_rd && !acc_wr |=> rd_valid_q)
		else $error("read strobe got no answer");
	a_rd_quiet: assert property (
		!(acc_rd && !acc_wr) |=> !rd_valid_q)
		else $error("read answer without a read strobe");

	c_sram_rw: cover property (
		acc_wr && sel_ptr ##2 acc_rd && sel_data);
	c_pm_page: cover property (acc_wr && sel_page);
	c_protect_slew: cover property (
		s_q.protect_go && s_q.dev_mode[9:8] == 2'b11);
	c_bcast: cover property (bc_load && channel_broadcast_enable != '0);

endmodule

/* sim/dmib_host.sv */
// Purpose: Host model issuing decoded single-word register accesses.
// Assumes: Requests launch on the falling clock edge, one idle cycle apart.
// Notes:   Address and data lines carry inverted junk while idle.
`timescale 1ns/10ps

module dmib_host (
	input wire logic clock,
	output logic acc_wr,
	output logic acc_rd,
	output logic acc_pmbus,
	output logic [7:0] acc_addr,
	output logic [15:0] acc_wdata,
	input wire logic [15:0] rd_data_q,
	input wire logic rd_valid_q
);
	// Lowest-power setting the host applies
	localparam logic [15:0] LOW_POWER = 16'h2000;

	initial
	begin
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_pmbus = 1'b0;
		acc_addr = 8'h00;
		acc_wdata = 16'h0000;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic pm, input logic [7:0] a,
		input logic [15:0] d);
	begin
		@(negedge clock);
		acc_pmbus = pm;
		acc_addr = a;
		acc_wdata = d;
		acc_wr = 1'b1;
		@(negedge clock);
		acc_wr = 1'b0;
		acc_addr = ~a;
		acc_wdata = ~d;
	end
	endtask

	// Answer sampled one cycle after the read edge
	task automatic rd(input logic pm, input logic [7:0] a,
		output logic [16:0] r);
	begin
		@(negedge clock);
		acc_pmbus = pm;
		acc_addr = a;
		acc_rd = 1'b1;
		@(negedge clock);
		r = {rd_valid_q, rd_data_q};
		acc_rd = 1'b0;
		acc_addr = ~a;
	end
	endtask
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the mode, interface, scratch and
//          broadcast register group.
// Assumes: Inputs change on the falling edge; fixed random seed.
// Notes:   Slew interval shortened to two cycles.
`timescale 1ns/10ps

module tb
	import dmib_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n, wr, rd, pmb, gpi_en, gpio_in, sdo;
	logic [7:0] addr, p;
	logic [15:0] wdata, rdata, d, mv;
	logic rvalid, lp, tmo, pme, fast, gout, goe;
	logic [3:0] gcfg;
	logic [1:0] bc_en, hiz;
	logic [23:0] nvm, mlow, mhigh, code, ex;
	logic [11:0] b, k;
	logic [11:0] cur [2];
	logic [15:0] w [4];
	logic [16:0] r;
	logic [7:0] regs [5] = '{ADDR_DEV_MODE, ADDR_IFC, ADDR_PTR, ADDR_DATA,
		ADDR_BCAST};
	int errors = 0, checks_done = 0, cycles = 0, i, j, n, act;

	always #25 clock = ~clock;

	dmib_host dmib_host_i (.clock(clock), .acc_wr(wr), .acc_rd(rd),
		.acc_pmbus(pmb), .acc_addr(addr), .acc_wdata(wdata),
		.rd_data_q(rdata), .rd_valid_q(rvalid));

	dmib_regs #(.NCH(2), .RES(12), .SRAM_DEPTH(256), .SLEW_CYCLES(2))
		dmib_regs_i (.clock(clock), .rst_n(rst_n), .acc_wr(wr),
		.acc_rd(rd), .acc_pmbus(pmb), .acc_addr(addr), .acc_wdata(wdata),
		.rd_data_q(rdata), .rd_valid_q(rvalid), .gpi_enable(gpi_en),
		.gpi_config(gcfg), .gpio_in(gpio_in), .spi_sdo(sdo),
		.channel_broadcast_enable(bc_en), .nvm_code(nvm),
		.margin_low(mlow), .margin_high(mhigh), .dac_code(code),
		.dac_hiz(hiz), .low_power_select_q(lp), .i2c_timeout_en_q(tmo),
		.pmbus_en_q(pme), .fast_readback_enable_q(fast),
		.gpio_out_q(gout), .gpio_oe_q(goe));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] bc_code(input logic [15:0] v);
		return v[15:4];
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
	begin
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	end
	endtask

	task automatic rchk(input string nm, input logic pm, input logic [7:0] a,
		input logic [15:0] e);
	begin
		dmib_host_i.rd(pm, a, r);
		chk(nm, {1'b1, e}, r);
	end
	endtask

	task automatic do_reset;
	begin
		rst_n = 1'b0;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
	end
	endtask

	task automatic conclude;
	begin
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// Worst case is four protects, two of them slewed, plus register traffic
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(90842));
		{gpi_en, gcfg, gpio_in, sdo} = {1'b1, GPI_PROTECT, 1'b1, 1'b0};
		{bc_en, nvm, mlow, mhigh} = '0;
		do_reset();
		for (i = 0; i < 5; i++)
			rchk("reset", 1'b0, regs[i], 16'h0000);
		chk("reset_outs", 0, {lp, tmo, pme, fast, goe});
		$display("test reset done");
		for (i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 16'hFFFF : 16'($urandom);
			sdo = 1'($urandom);
			dmib_host_i.wr(1'b0, ADDR_IFC, d);
			rchk("ifc", 1'b0, ADDR_IFC, d & MASK_IFC);
			chk("ifc_outs", {d[12], d[8], d[2]}, {tmo, pme, fast});
			chk("readback", {d[0], d[0] & sdo}, {goe, gout});
			mv = (i == 0) ? dmib_host_i.LOW_POWER : 16'($urandom);
			dmib_host_i.wr(1'b0, ADDR_DEV_MODE, mv);
			rchk("mode", 1'b0, ADDR_DEV_MODE, mv);
			chk("low_power", mv[13], lp);
		end
		$display("test config done");
		for (i = 0; i < 3; i++)
		begin
			p = (i == 0) ? 8'hFE : 8'($urandom);
			dmib_host_i.wr(1'b0, ADDR_PTR, {8'($urandom), p});
			rchk("pointer", 1'b0, ADDR_PTR, {8'h00, p});
			for (j = 0; j < 4; j++)
			begin
				w[j] = 16'($urandom);
				dmib_host_i.wr(1'b0, ADDR_DATA, w[j]);
			end
			rchk("ptr_inc", 1'b0, ADDR_PTR, {8'h00, 8'(p + 4)});
			for (j = 0; j < 4; j++)
			begin
				dmib_host_i.wr(1'b0, ADDR_PTR, {8'h00, 8'(p + j)});
				rchk("word", 1'b0, ADDR_DATA, w[j]);
				rchk("reread", 1'b0, ADDR_DATA, w[j]);
			end
			rchk("ptr_kept", 1'b0, ADDR_PTR, {8'h00, 8'(p + 3)});
		end
		$display("test scratch done");
		cur = '{12'h000, 12'h000};
		for (i = 0; i < 8; i++)
		begin
			bc_en = (i == 0) ? 2'b11 : 2'($urandom);
			d = (i == 0) ? 16'hFFFF : 16'($urandom);
			dmib_host_i.wr(1'b0, ADDR_BCAST, d);
			for (j = 0; j < 2; j++)
				if (bc_en[j])
					cur[j] = bc_code(d);
			chk("dac_code", {cur[1], cur[0]}, code);
			rchk("bcast", 1'b0, ADDR_BCAST, d & MASK_BCAST);
		end
		$display("test broadcast done");
		dmib_host_i.wr(1'b0, ADDR_IFC, 16'h0100);
		rchk("page_rst", 1'b1, PM_PAGE_CMD, RST_PAGE_REG);
		rchk("off_page", 1'b1, PM_DEV_MODE, 16'h0000);
		dmib_host_i.wr(1'b1, PM_PAGE_CMD, 16'hFF5A);
		rchk("page", 1'b1, PM_PAGE_CMD, 16'hFF00);
		rchk("pm_mode", 1'b1, PM_DEV_MODE, mv);
		dmib_host_i.wr(1'b1, PM_PTR, 16'h0012);
		dmib_host_i.wr(1'b1, PM_DATA, 16'h1234);
		rchk("pm_ptr", 1'b1, PM_PTR, 16'h0013);
		dmib_host_i.wr(1'b0, ADDR_PTR, 16'h0012);
		rchk("pm_data", 1'b1, PM_DATA, 16'h1234);
		dmib_host_i.wr(1'b1, PM_BCAST, 16'hA5C3);
		rchk("pm_bcast", 1'b1, PM_BCAST, 16'hA5C0);
		dmib_host_i.wr(1'b0, ADDR_IFC, 16'h0000);
		rchk("pm_off", 1'b1, PM_PAGE_CMD, 16'h0000);
		dmib_host_i.wr(1'b1, PM_PAGE_CMD, 16'h0700);
		dmib_host_i.wr(1'b0, ADDR_IFC, 16'h0100);
		rchk("pm_gate", 1'b1, PM_PAGE_CMD, 16'hFF00);
		$display("test pmbus done");
		for (act = 0; act < 4; act++)
		begin
			do_reset();
			bc_en = 2'b11;
			b = 12'(100 + $urandom % 3800);
			k = 12'(4 + $urandom % 37);
			nvm = 24'($urandom);
			mlow = {b - k, b - k};
			mhigh = {b + k, b + k};
			dmib_host_i.wr(1'b0, ADDR_BCAST, {b, 4'h0});
			dmib_host_i.wr(1'b0, ADDR_DEV_MODE, {6'h00, 2'(act), 8'h00});
			gcfg = 4'h4;
			gpio_in = 1'b0;
			repeat (6) @(negedge clock);
			chk("no_protect", 2'b00, hiz);
			gpio_in = 1'b1;
			gcfg = GPI_PROTECT;
			@(negedge clock);
			gpio_in = 1'b0;
			for (n = 0; n < 1000 && hiz !== 2'b11; n++)
				@(negedge clock);
			ex = (act == 0) ? {b, b} : (act == 1) ? nvm :
				(act == 2) ? mlow : mhigh;
			chk("protect_code", ex, code);
			chk("no_slew", act < 2, n <= 4);
			gpio_in = 1'b1;
		end
		$display("test protect done");
		conclude();
	end
endmodule
